// ===== core/dpm_pkg.sv
package dpm_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int unsigned DPM_ADDR_W      = 8;               // apb address width
   localparam int unsigned DPM_NPIN        = 2;               // pin 0 = phase a, pin 1 = phase b
   localparam logic [7:0]  DPM_OFS_PINCFG  = 8'h00;           // system_pin_config_register
   localparam logic [7:0]  DPM_OFS_PULLUP  = 8'h04;           // port_c_pullup_register
   localparam logic [7:0]  DPM_OFS_GPIOEN  = 8'h08;           // port c line claim
   localparam logic [7:0]  DPM_OFS_GPIODIR = 8'h0C;           // port c direction, 1 = output
   localparam logic [7:0]  DPM_OFS_GPIODAT = 8'h10;           // port c output data
   localparam logic [7:0]  DPM_OFS_PADIN   = 8'h14;           // pad level, read only
   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned DPM_BIT_PHA     = 0;               // phase a pin bit in each register
   localparam int unsigned DPM_BIT_PHB     = 1;               // phase b pin bit in each register
   localparam logic [1:0]  DPM_RST_PINCFG  = 2'h0;            // decoder function selected
   localparam logic [1:0]  DPM_RST_PULLUP  = 2'h3;            // both pull-ups on
   localparam logic [1:0]  DPM_RST_GPIO    = 2'h0;            // lines unclaimed, inputs, low
   // ----------------------------------------------------------------
   // pin functions
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DPM_FN_NONE = 2'b00,                                    // reduced variant before setup
      DPM_FN_DEC  = 2'b01,                                    // decoder / timer channel
      DPM_FN_SPI  = 2'b10,                                    // second serial interface
      DPM_FN_GPIO = 2'b11                                     // port c line
   } dpm_func_t;
endpackage : dpm_pkg

// ===== core/dpm_pin_cell.sv
`timescale 1ns/1ps
// one pad: function mux, registered pad controls and input routing
module dpm_pin_cell
   import dpm_pkg::*;
(
   input  wire logic      pclk,
   input  wire logic      presetn,
   input  wire dpm_pkg::dpm_func_t func,  // selected function
   input  wire logic      pullup_en,      // pull-up request
   input  wire logic      gpio_dir,       // 1 = output
   input  wire logic      gpio_dat,       // port output value
   input  wire logic      timer_out,      // timer channel output value
   input  wire logic      timer_oe,       // timer channel wants the pad
   input  wire logic      spi_out,        // serial clock or master-out value
   input  wire logic      spi_drive,      // serial block is master
   input  wire logic      pad_in,         // pad level
   output logic           pad_out,        // pad drive value
   output logic           pad_oe_n,       // low while driving
   output logic           pad_pullup_en,  // internal pull-up on
   output logic           dec_in,         // to decoder
   output logic           timer_in,       // to timer channel
   output logic           spi_in          // to serial block
);
   logic nxt_out;                         // next pad value
   logic nxt_oe_n;                        // next pad enable

   // ----------------------------------------------------------------
   // output mux
   // ----------------------------------------------------------------
   always_comb begin
      nxt_out  = 1'b0;
      nxt_oe_n = 1'b1;
      case (func)
         DPM_FN_DEC: begin                // input unless timer drives
            nxt_out  = timer_out;
            nxt_oe_n = ~timer_oe;
         end
         DPM_FN_SPI: begin                // master drives, slave listens
            nxt_out  = spi_out;
            nxt_oe_n = ~spi_drive;
         end
         DPM_FN_GPIO: begin               // per-line direction
            nxt_out  = gpio_dat;
            nxt_oe_n = ~gpio_dir;
         end
         default: begin                   // no usable function: float
            nxt_out  = 1'b0;
            nxt_oe_n = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // pad registers; one cycle for every path keeps data/clock skew
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out       <= 1'b0;
         pad_oe_n      <= 1'b1;
         pad_pullup_en <= 1'b1;           // pull-up on in reset
      end else begin
         pad_out       <= nxt_out;
         pad_oe_n      <= nxt_oe_n;
         pad_pullup_en <= pullup_en;
      end
   end

   // ----------------------------------------------------------------
   // input routing
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_in   <= 1'b0;
         timer_in <= 1'b0;
         spi_in   <= 1'b0;
      end else begin
         dec_in   <= (func == DPM_FN_DEC) & pad_in;
         timer_in <= (func == DPM_FN_DEC) & pad_in;
         spi_in   <= (func == DPM_FN_SPI) & ~spi_drive & pad_in;   // slave input
      end
   end
endmodule : dpm_pin_cell

// ===== core/dpm_top.sv
`timescale 1ns/1ps
module dpm_top
   import dpm_pkg::*;
#(
   parameter bit HAS_DECODER = 1'b1                        // 0 = reduced variant
)(
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [dpm_pkg::DPM_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic [dpm_pkg::DPM_NPIN-1:0]   pad_in,              // pad levels
   output logic      [dpm_pkg::DPM_NPIN-1:0]   pad_out,
   output logic      [dpm_pkg::DPM_NPIN-1:0]   pad_oe_n,
   output logic      [dpm_pkg::DPM_NPIN-1:0]   pad_pullup_en,
   output logic                                decoder1_phase_a_in,
   output logic                                decoder1_phase_b_in,
   input  wire logic [dpm_pkg::DPM_NPIN-1:0]   timer_b_channel_out, // bit 0 = channel zero
   input  wire logic [dpm_pkg::DPM_NPIN-1:0]   timer_b_channel_oe,
   output logic      [dpm_pkg::DPM_NPIN-1:0]   timer_b_channel_in,
   input  wire logic                           spi_master_mode,     // serial block is master
   input  wire logic                           spi_second_serial_clock_out,
   output logic                                spi_second_serial_clock_in,
   input  wire logic                           spi_second_master_out_out,
   output logic                                spi_second_master_out_in
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [DPM_NPIN-1:0] pincfg_ff;       // alternate selects
   logic [DPM_NPIN-1:0] pullup_ff;       // pull-up enables
   logic [DPM_NPIN-1:0] gpioen_ff;       // port line claims
   logic [DPM_NPIN-1:0] gpiodir_ff;      // port directions
   logic [DPM_NPIN-1:0] gpiodat_ff;      // port outputs
   logic [DPM_NPIN-1:0] setup_ff;        // function made usable
   logic                pready_ff;       // access ending
   logic [31:0]         prdata_ff;       // read data
   logic                pslverr_ff;      // unmapped access
   logic [31:0]         nxt_rdata;       // read mux
   logic                nxt_hit;         // address decodes
   logic                wr_fire;         // write takes effect
   dpm_func_t           func [DPM_NPIN]; // per-pin function
   logic [DPM_NPIN-1:0] spi_out;         // serial values per pin
   logic [DPM_NPIN-1:0] dec_in;          // decoder inputs per pin
   logic [DPM_NPIN-1:0] spi_in;          // serial inputs per pin

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign wr_fire = psel & penable & pready_ff & pwrite & nxt_hit;

   // ----------------------------------------------------------------
   // function decode: port claim, then alternate, then decoder
   // ----------------------------------------------------------------
   function automatic dpm_func_t pick_func(input logic ok, input logic gp, input logic alt);
      if (!ok)
         return DPM_FN_NONE;
      else if (gp)
         return DPM_FN_GPIO;
      else if (alt)
         return DPM_FN_SPI;
      else
         return DPM_FN_DEC;
   endfunction : pick_func

   // ----------------------------------------------------------------
   // apb: one wait state, write at the completing edge
   // ----------------------------------------------------------------
   always_comb begin
      nxt_hit   = 1'b1;
      nxt_rdata = 32'h0000_0000;
      case (paddr)
         DPM_OFS_PINCFG:  nxt_rdata[DPM_NPIN-1:0] = pincfg_ff;
         DPM_OFS_PULLUP:  nxt_rdata[DPM_NPIN-1:0] = pullup_ff;
         DPM_OFS_GPIOEN:  nxt_rdata[DPM_NPIN-1:0] = gpioen_ff;
         DPM_OFS_GPIODIR: nxt_rdata[DPM_NPIN-1:0] = gpiodir_ff;
         DPM_OFS_GPIODAT: nxt_rdata[DPM_NPIN-1:0] = gpiodat_ff;
         DPM_OFS_PADIN:   nxt_rdata[DPM_NPIN-1:0] = pad_in;
         default:         nxt_hit = 1'b0;   // unmapped: error, reads zero
      endcase
   end

   // handshake flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= psel & penable & ~pready_ff;
         prdata_ff  <= (psel & penable & ~pready_ff & ~pwrite) ? nxt_rdata : 32'h0000_0000;
         pslverr_ff <= psel & penable & ~pready_ff & ~nxt_hit;
      end
   end

   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pincfg_ff  <= DPM_RST_PINCFG;
         pullup_ff  <= DPM_RST_PULLUP;
         gpioen_ff  <= DPM_RST_GPIO;
         gpiodir_ff <= DPM_RST_GPIO;
         gpiodat_ff <= DPM_RST_GPIO;
      end else if (wr_fire) begin
         case (paddr)
            DPM_OFS_PINCFG:  pincfg_ff  <= pwdata[DPM_NPIN-1:0];
            DPM_OFS_PULLUP:  pullup_ff  <= pwdata[DPM_NPIN-1:0];
            DPM_OFS_GPIOEN:  gpioen_ff  <= pwdata[DPM_NPIN-1:0];
            DPM_OFS_GPIODIR: gpiodir_ff <= pwdata[DPM_NPIN-1:0];
            DPM_OFS_GPIODAT: gpiodat_ff <= pwdata[DPM_NPIN-1:0];
            default:         gpiodat_ff <= gpiodat_ff;            // read-only pad register
         endcase
      end
   end

   // reduced variant: pins stay dead until pin config or claim is written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         setup_ff <= {DPM_NPIN{HAS_DECODER}};
      else if (wr_fire && (paddr == DPM_OFS_PINCFG || paddr == DPM_OFS_GPIOEN))
         setup_ff <= {DPM_NPIN{1'b1}};
   end

   // ----------------------------------------------------------------
   // pad cells
   // ----------------------------------------------------------------
   assign spi_out[DPM_BIT_PHA] = spi_second_serial_clock_out;
   assign spi_out[DPM_BIT_PHB] = spi_second_master_out_out;

   for (genvar i = 0; i < DPM_NPIN; i++) begin : g_pin
      assign func[i] = pick_func(setup_ff[i], gpioen_ff[i], pincfg_ff[i]);
      dpm_pin_cell u_cell (
         .pclk          (pclk),
         .presetn       (presetn),
         .func          (func[i]),
         .pullup_en     (pullup_ff[i]),
         .gpio_dir      (gpiodir_ff[i]),
         .gpio_dat      (gpiodat_ff[i]),
         .timer_out     (timer_b_channel_out[i]),
         .timer_oe      (timer_b_channel_oe[i]),
         .spi_out       (spi_out[i]),
         .spi_drive     (spi_master_mode),
         .pad_in        (pad_in[i]),
         .pad_out       (pad_out[i]),
         .pad_oe_n      (pad_oe_n[i]),
         .pad_pullup_en (pad_pullup_en[i]),
         .dec_in        (dec_in[i]),
         .timer_in      (timer_b_channel_in[i]),
         .spi_in        (spi_in[i])
      );
   end

   assign decoder1_phase_a_in        = dec_in[DPM_BIT_PHA];
   assign decoder1_phase_b_in        = dec_in[DPM_BIT_PHB];
   assign spi_second_serial_clock_in = spi_in[DPM_BIT_PHA];
   assign spi_second_master_out_in   = spi_in[DPM_BIT_PHB];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_pullup_wr;
      psel && penable && pready && pwrite && paddr == DPM_OFS_PULLUP;
   endsequence

   sequence s_both_spi_master;
      func[0] == DPM_FN_SPI && func[1] == DPM_FN_SPI && spi_master_mode;
   endsequence

   chk_dec_route_a: assert property (func[0] == DPM_FN_DEC |=>
      decoder1_phase_a_in == $past(pad_in[0]) && timer_b_channel_in[0] == $past(pad_in[0]))
      else $error("phase a pin not routed to decoder");
   chk_dec_route_b: assert property (func[1] == DPM_FN_DEC && !timer_b_channel_oe[1] |=>
      decoder1_phase_b_in == $past(pad_in[1]) && pad_oe_n[1])
      else $error("phase b pin not routed to decoder");
   chk_none_float: assert property (!setup_ff[0] |=> pad_oe_n[0] && !decoder1_phase_a_in)
      else $error("unconfigured pin is active");
   chk_spi_aligned: assert property (s_both_spi_master |=>
      !pad_oe_n[0] && !pad_oe_n[1] && pad_out[0] == $past(spi_second_serial_clock_out)
      && pad_out[1] == $past(spi_second_master_out_out))
      else $error("serial clock and data not aligned");
   // phase b select with a master block puts master-out data on the pin
   chk_mosi_alt: assert property (pincfg_ff[1] && !gpioen_ff[1] && setup_ff[1] && spi_master_mode
      |=> !pad_oe_n[1] && pad_out[1] == $past(spi_second_master_out_out))
      else $error("phase b select not honoured");
   chk_sclk_slave: assert property (func[0] == DPM_FN_SPI && !spi_master_mode |=>
      pad_oe_n[0] && spi_second_serial_clock_in == $past(pad_in[0]))
      else $error("slave serial clock not taken from pin");
   chk_pullup_wr: assert property (s_pullup_wr |-> ##2
      pad_pullup_en == $past(pwdata[1:0], 2))
      else $error("pull-up write not applied");
   chk_pullup_b: assert property (!pullup_ff[1] ##1 !pullup_ff[1] |-> !pad_pullup_en[1])
      else $error("phase b pull-up still on");
   chk_gpio_dir: assert property (func[0] == DPM_FN_GPIO |=>
      pad_oe_n[0] == !$past(gpiodir_ff[0]) && (pad_oe_n[0] || pad_out[0] == $past(gpiodat_ff[0])))
      else $error("port line direction wrong");
   chk_sclk_alt: assert property (func[0] == DPM_FN_SPI && spi_master_mode |=>
      !pad_oe_n[0] && pad_out[0] == $past(spi_second_serial_clock_out))
      else $error("serial clock not driven on phase a pin");
   // one wait state on every access
   chk_apb_wait: assert property (psel && penable && !pready |=> pready)
      else $error("apb access not completed");
   // error only ever flags a completing access
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   // full variant hands both pins to the decoder out of reset
   chk_reset_func: assert property (HAS_DECODER && $rose(presetn) |->
      func[0] == DPM_FN_DEC && func[1] == DPM_FN_DEC)
      else $error("pins not on decoder after reset");
endmodule : dpm_top

// ===== testbench/dpm_peer.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-side pad model: outside drivers, pull-ups, floating lines
// ----------------------------------------------------------------
module dpm_peer
   import dpm_pkg::*;
(
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic [dpm_pkg::DPM_NPIN-1:0] pad_out,
   input  wire logic [dpm_pkg::DPM_NPIN-1:0] pad_oe_n,
   input  wire logic [dpm_pkg::DPM_NPIN-1:0] pad_pullup_en,
   input  wire logic [dpm_pkg::DPM_NPIN-1:0] peer_drive,    // far side drives the line
   input  wire logic [dpm_pkg::DPM_NPIN-1:0] peer_val,      // far side value
   output logic      [dpm_pkg::DPM_NPIN-1:0] pad_in
);
   logic [DPM_NPIN-1:0] float_ff;                  // pattern seen on an undriven line
   // undriven line without pull-up keeps changing, never a stale value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         float_ff <= 2'h1;
      end else begin
         float_ff <= ~float_ff;
      end
   end
   // wire level from every party's enable
   always_comb begin
      for (int i = 0; i < DPM_NPIN; i++) begin
         if (!pad_oe_n[i]) begin
            pad_in[i] = pad_out[i];                // device drives
         end else if (peer_drive[i]) begin
            pad_in[i] = peer_val[i];               // far side drives, data set up while clock low
         end else if (pad_pullup_en[i]) begin
            pad_in[i] = 1'b1;                      // pulled up
         end else begin
            pad_in[i] = float_ff[i];               // floating
         end
      end
   end
endmodule : dpm_peer

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
   import dpm_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er, ma_in, mb_in, sclk_in, mosi_in;
   logic [1:0]  pad_in, pad_out, pad_oe_n, pull_en, tmr_in;
   logic [1:0]  tmr_out = 2'h0, tmr_oe = 2'h0, peer_drive = 2'h3, peer_val = 2'h2;
   logic        master = 0, sclk_out = 0, mosi_out = 0;
   logic        r_ma, r_mb;                                      // reduced variant decoder inputs
   logic [1:0]  r_oe_n, r_tmr;                                   // reduced variant pad enables, timer inputs
   int          fails = 0, checks_done = 0;
   logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};  // register offsets
   logic [1:0]  rst [5] = '{2'h0, 2'h3, 2'h0, 2'h0, 2'h0};       // reset values
   always #5 pclk = ~pclk;
   dpm_top dpm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pull_en), .decoder1_phase_a_in(ma_in),
      .decoder1_phase_b_in(mb_in), .timer_b_channel_out(tmr_out), .timer_b_channel_oe(tmr_oe),
      .timer_b_channel_in(tmr_in), .spi_master_mode(master), .spi_second_serial_clock_out(sclk_out),
      .spi_second_serial_clock_in(sclk_in), .spi_second_master_out_out(mosi_out),
      .spi_second_master_out_in(mosi_in));
   dpm_peer dpm_peer_i (.pclk(pclk), .presetn(presetn), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pullup_en(pull_en), .peer_drive(peer_drive), .peer_val(peer_val), .pad_in(pad_in));
   // reduced variant on the same bus: pins stay dead until software sets them up
   dpm_top #(.HAS_DECODER(1'b0)) dpm_top_reduced_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
      .pad_in(pad_in), .pad_out(), .pad_oe_n(r_oe_n), .pad_pullup_en(), .decoder1_phase_a_in(r_ma),
      .decoder1_phase_b_in(r_mb), .timer_b_channel_out(tmr_out), .timer_b_channel_oe(tmr_oe),
      .timer_b_channel_in(r_tmr), .spi_master_mode(master), .spi_second_serial_clock_out(sclk_out),
      .spi_second_serial_clock_in(), .spi_second_master_out_out(mosi_out), .spi_second_master_out_in());
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin
         fails++;
         results();
      end
   endtask : apb
   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask : done
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      #500000;
      fails++;
      results();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk(ma_in, 1'b0);
      chk(mb_in, 1'b1);
      chk(tmr_in, 2'h2);
      chk(pull_en, 2'h3);
      chk(r_oe_n, 2'h3);
      chk({r_ma, r_mb, r_tmr}, 4'h0);
      @(posedge pclk);
      tmr_oe <= 2'h1; tmr_out <= 2'h1;
      settle();
      chk({pad_oe_n, pad_out[0]}, 3'b101);
      chk(r_oe_n, 2'h3);
      @(posedge pclk);
      tmr_oe <= 2'h0;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ofs[i], 32'h0);
         chk(rd, {30'h0, rst[i]});
      end
      apb(1'b0, 8'h18, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      done("decoder and reset");
      apb(1'b1, DPM_OFS_PULLUP, 32'h1);
      settle();
      chk(pull_en, 2'h1);
      apb(1'b1, DPM_OFS_PULLUP, 32'h2);
      settle();
      chk(pull_en, 2'h2);
      apb(1'b1, DPM_OFS_PULLUP, 32'h3);
      done("pull-ups");
      @(posedge pclk);
      master <= 1'b1; sclk_out <= 1'b1; mosi_out <= 1'b1; peer_drive <= 2'h0;
      apb(1'b1, DPM_OFS_PINCFG, 32'h3);
      settle();
      chk({pad_oe_n, pad_out}, 4'b0011);
      chk({ma_in, mb_in}, 2'h0);
      chk(r_oe_n, 2'h0);
      @(posedge pclk);
      sclk_out <= 1'b0;
      settle();
      chk(pad_out[0], 1'b0);
      @(posedge pclk);
      master <= 1'b0; peer_drive <= 2'h3;
      for (int b = 0; b < 4; b++) begin
         @(posedge pclk);
         peer_val <= {b[0], 1'b0};                 // data leads the rising clock
         @(posedge pclk);
         peer_val <= {b[0], 1'b1};
         settle();
         chk({pad_oe_n, sclk_in, mosi_in}, {3'b111, b[0]});
      end
      done("serial");
      apb(1'b1, DPM_OFS_GPIOEN, 32'h3);
      apb(1'b1, DPM_OFS_GPIODIR, 32'h1);
      apb(1'b1, DPM_OFS_GPIODAT, 32'h1);
      @(posedge pclk);
      peer_drive <= 2'h2; peer_val <= 2'h0;
      settle();
      chk({pad_oe_n, pad_out[0]}, 3'b101);
      apb(1'b1, DPM_OFS_PADIN, 32'h2);
      chk(er, 1'b0);
      apb(1'b0, DPM_OFS_PADIN, 32'h0);
      chk(rd, 32'h1);
      @(posedge pclk);
      peer_drive <= 2'h1; peer_val <= 2'h1;
      apb(1'b1, DPM_OFS_GPIODIR, 32'h2);
      apb(1'b1, DPM_OFS_GPIODAT, 32'h0);
      settle();
      chk({pad_oe_n, pad_out[1]}, 3'b010);
      done("port lines");
      results();
   end
endmodule : tb
